// *** design/sysctl_pkg.sv ***
/*
  package for the system control low-field register block: offsets, field positions,
  reset values, timing counts, carrier structs.
  assumes: a single 125 MHz host bus clock, synchronous active-low reset.
*/
`default_nettype none
package sysctl_pkg;
  // register map (byte addresses)
  localparam logic [7:0]  SYSCTL_OFFSET      = 8'h00;  // system control register
  localparam logic [7:0]  SYSCTL_AUX_OFFSET  = 8'h04;  // pin/legacy control register
  // field positions of system control
  localparam int          UP_BURST_BIT       = 14;
  localparam int          ACTIVITY_BIT       = 13;
  localparam int          RSVD_ONE_BIT       = 12;
  localparam int          STREAM_BIT         = 11;
  localparam int          UP_DELAY_BIT       = 10;
  localparam int          DOWN_DELAY_BIT     = 9;
  localparam int          PROBE_BIT          = 8;
  localparam int          AUTO_GATE_BIT      = 7;
  localparam int          IDLE_GATE_BIT      = 6;
  localparam int          ID_LOCK_BIT        = 5;
  localparam int          PARITY_BIT         = 4;
  localparam int          CDMA_BIT           = 3;
  localparam int          SUPPLY_BIT         = 2;
  localparam int          HOLD_CLOCKS_RUNNING_BIT        = 1;
  localparam int          MUX_BIT            = 0;
  localparam int          DOWN_BURST_BIT     = 15;
  // aux register field positions
  localparam int          LEGACY_MODE_BIT    = 0;
  localparam int          PINS_CDMA_BIT      = 1;
  // writable-field masks and reset values of system control and the aux register
  localparam logic [31:0] SYSCTL_WR_MASK     = 32'h0000_c0ff;
  localparam logic [31:0] SYSCTL_RESET       = 32'h0000_8020;
  localparam logic [31:0] AUX_WR_MASK        = 32'h0000_0003;
  localparam logic [31:0] AUX_RESET          = 32'h0000_0000;
  // settling delays after a switch stream
  localparam int          CLK_MHZ            = 125;
  localparam int          UP_DELAY_US        = 10;
  localparam int          DOWN_DELAY_US      = 10;
  localparam int          UP_DELAY_CYC       = UP_DELAY_US * CLK_MHZ;
  localparam int          DOWN_DELAY_CYC     = DOWN_DELAY_US * CLK_MHZ;
  localparam int          DELAY_W            = 16;
  // axi response codes
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // card-side status into the block
  typedef struct packed {
    logic card_access;      // pulse per card access
    logic stream_start_up;  // pulse: power-up stream begins
    logic stream_start_dn;  // pulse: power-down stream begins
    logic stream_done;      // pulse: stream finished sending
    logic probe_busy;       // socket interrogation running
    logic card_is_32bit;    // inserted card is a 32-bit card
    logic card_idle;        // card state machine idle
    logic card_clk_stopped; // card clock stopped
    logic card_parity_err;  // data parity error on card bus
    logic ring_req;         // ring-indicate source
    logic pme_req;          // power-management event source
  } sysctl_stat_s;

  // controls out of the block
  typedef struct packed {
    logic upstream_read_burst_en;
    logic downstream_read_burst_en;
    logic auto_switch_gate;
    logic card_sm_clk_en;
    logic id_write_lock;
    logic syserr_req;
    logic central_dma_en;
    logic legacy_supply_5v;
    logic hold_clocks_running;
    logic wake_pin_out;
  } sysctl_ctl_s;
endpackage
`default_nettype wire

// *** design/sysctl_sync.sv ***
/*
  three-stage synchroniser with agreement filter for one pin-level input.
  assumes: input is asynchronous to aclk; output changes only when stages two and three agree.
*/
`default_nettype none
module sysctl_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output var  logic dout
);
  logic s1_ff;  // metastability catcher, read only by s2
  logic s2_ff;
  logic s3_ff;
  logic dout_ff;

  // shift chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accept a change only once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      dout_ff <= s3_ff;
    end
  end

  assign dout = dout_ff;
endmodule
`default_nettype wire

// *** design/sysctl_delay.sv ***
/*
  settling delay timer: a start pulse raises busy, busy falls after LEN cycles.
  assumes: start is a same-clock pulse; a restart reloads the count.
*/
`default_nettype none
module sysctl_delay #(
  parameter int LEN = 1250
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output var  logic busy
);
  localparam logic [sysctl_pkg::DELAY_W-1:0] LOAD = sysctl_pkg::DELAY_W'(LEN - 1);
  logic [sysctl_pkg::DELAY_W-1:0] cnt_ff;  // cycles left
  logic                           busy_ff;

  // load on start, count down while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else if (start) begin
      cnt_ff  <= LOAD;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign busy = busy_ff;
endmodule
`default_nettype wire

// *** design/sysctl_regs.sv ***
/*
  system control register, bits 15..0, behind an axi4-lite slave, plus the control
  outputs that its fields steer.
  assumes: card-side status comes from same-clock logic except the ring and pme
  sources, which are pins and are synchronised here.
*/
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
// Behaviour
// R1 - bit 14 enables upstream memory read bursts
// R2 - bit 13 sets on card access, clears on read
// R3 - bit 12 always reads one, ignores writes
// R4 - bit 11 busy from request until stream+delay done
// R5 - bit 10 high after power-up stream until delay
// R6 - bit 9 high after power-down stream until delay
// R7 - bit 8 shows socket interrogation in progress
// R8 - bit 7 gates legacy auto power switch control
// R9 - bit 6 stops idle clockless 32-bit card machine
// R10 - bit 5 locks identifier registers, default locked
// R11 - bit 4 forwards card parity errors to syserr
// R12 - bit 3 enables central dma if pins allow
// R13 - bit 2 selects legacy supply, 0=3.3V 1=5V
// R14 - bit 1 keeps both bus clocks running
// R15 - bit 0 selects ring/pme sharing on wake pin
// R16 - status writes ignored, writable fields reset defaults
// R17 - bit 15 enables downstream bursts, default on
`default_nettype none
module sysctl_regs (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  // write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  // write response
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // read address
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  // read data
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // card side
  input  wire sysctl_pkg::sysctl_stat_s stat,
  output var  sysctl_pkg::sysctl_ctl_s  ctl
);
  logic [31:0] ctl_reg_ff;     // writable fields of system control
  logic [31:0] aux_reg_ff;     // legacy mode and pin-config bits
  logic        activity_ff;    // sticky card-access flag
  logic        stream_ff;      // stream-or-delay busy
  logic        aw_hold_ff;     // write address captured
  logic [7:0]  aw_addr_ff;
  logic        w_hold_ff;      // write data captured
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        awready_ff;     // ready outputs kept in their own flops
  logic        wready_ff;
  logic        arready_ff;
  logic        dn_pending_ff;  // next settling delay is the power-down one
  logic        waiting_ff;     // stream sent, settling delay running
  logic        ctl_busy;       // combined delay busy
  logic        up_busy;
  logic        dn_busy;
  logic        ring_sync;
  logic        pme_sync;
  logic        do_write;
  logic        do_read;
  logic [31:0] wmask;
  logic [31:0] sys_view;
  sysctl_pkg::sysctl_ctl_s ctl_ff;

  // settling delays, one timer per direction
  sysctl_delay #(.LEN(sysctl_pkg::UP_DELAY_CYC)) u_up_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (stat.stream_done & stream_ff & ~dn_pending_ff),
    .busy    (up_busy)
  );
  sysctl_delay #(.LEN(sysctl_pkg::DOWN_DELAY_CYC)) u_dn_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (stat.stream_done & stream_ff & dn_pending_ff),
    .busy    (dn_busy)
  );

  // ring and pme arrive from pins
  sysctl_sync u_ring_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (stat.ring_req),
    .dout    (ring_sync)
  );
  sysctl_sync u_pme_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (stat.pme_req),
    .dout    (pme_sync)
  );

  assign ctl_busy = up_busy | dn_busy;
  assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign do_read  = s_axi_arvalid & ~rvalid_ff;

  // byte-lane mask from strobes
  always_comb begin
    wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  end

  // read view of system control
  always_comb begin
    sys_view = ctl_reg_ff;
    sys_view[sysctl_pkg::ACTIVITY_BIT]   = activity_ff;
    sys_view[sysctl_pkg::RSVD_ONE_BIT]   = 1'b1;             // R3
    sys_view[sysctl_pkg::STREAM_BIT]     = stream_ff;        // R4
    sys_view[sysctl_pkg::UP_DELAY_BIT]   = up_busy;          // R5
    sys_view[sysctl_pkg::DOWN_DELAY_BIT] = dn_busy;          // R6
    sys_view[sysctl_pkg::PROBE_BIT]      = stat.probe_busy;  // R7
  end

  // write address and data channels, accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid & ~aw_hold_ff) begin
      aw_hold_ff <= 1'b1;
      awready_ff <= 1'b0;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b1;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid & ~w_hold_ff) begin
      w_hold_ff <= 1'b1;
      wready_ff <= 1'b0;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= sysctl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      if (aw_addr_ff[7:2] == sysctl_pkg::SYSCTL_OFFSET[7:2] ||
          aw_addr_ff[7:2] == sysctl_pkg::SYSCTL_AUX_OFFSET[7:2]) begin
        bresp_ff <= sysctl_pkg::RESP_OKAY;
      end else begin
        bresp_ff <= sysctl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // writable fields; status bits masked off so writes cannot reach them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg_ff <= sysctl_pkg::SYSCTL_RESET;  // R16 R17 R1 R10
    end else if (do_write && aw_addr_ff[7:2] == sysctl_pkg::SYSCTL_OFFSET[7:2]) begin
      ctl_reg_ff <= (ctl_reg_ff & ~(wmask & sysctl_pkg::SYSCTL_WR_MASK)) |
                    (w_data_ff & wmask & sysctl_pkg::SYSCTL_WR_MASK);  // R16
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_reg_ff <= sysctl_pkg::AUX_RESET;
    end else if (do_write && aw_addr_ff[7:2] == sysctl_pkg::SYSCTL_AUX_OFFSET[7:2]) begin
      aux_reg_ff <= (aux_reg_ff & ~(wmask & sysctl_pkg::AUX_WR_MASK)) |
                    (w_data_ff & wmask & sysctl_pkg::AUX_WR_MASK);
    end
  end

  // pending stream direction, latched at stream start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dn_pending_ff <= 1'b0;
    end else if (stat.stream_start_dn) begin
      dn_pending_ff <= 1'b1;
    end else if (stat.stream_start_up) begin
      dn_pending_ff <= 1'b0;
    end
  end

  // stream busy: raised on request, held through the settling delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stream_ff <= 1'b0;
    end else if (stat.stream_start_up | stat.stream_start_dn) begin
      stream_ff <= 1'b1;  // R4
    end else if (waiting_ff & ~ctl_busy & ~stat.stream_done) begin
      stream_ff <= 1'b0;  // R4
    end
  end

  // stream phase tracker: after done, wait for delay to finish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waiting_ff <= 1'b0;
    end else if (stat.stream_start_up | stat.stream_start_dn) begin
      waiting_ff <= 1'b0;
    end else if (stream_ff & stat.stream_done) begin
      waiting_ff <= 1'b1;
    end else if (waiting_ff & ~ctl_busy & ~stat.stream_done) begin
      waiting_ff <= 1'b0;
    end
  end

  // socket activity: card access wins over the read side effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      activity_ff <= 1'b0;
    end else if (stat.card_access) begin
      activity_ff <= 1'b1;  // R2
    end else if (do_read && s_axi_araddr[7:2] == sysctl_pkg::SYSCTL_OFFSET[7:2]) begin
      activity_ff <= 1'b0;  // R2
    end
  end

  // read channel: one-cycle answer from registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= sysctl_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      if (s_axi_araddr[7:2] == sysctl_pkg::SYSCTL_OFFSET[7:2]) begin
        rdata_ff <= sys_view;
        rresp_ff <= sysctl_pkg::RESP_OKAY;
      end else if (s_axi_araddr[7:2] == sysctl_pkg::SYSCTL_AUX_OFFSET[7:2]) begin
        rdata_ff <= aux_reg_ff;
        rresp_ff <= sysctl_pkg::RESP_OKAY;
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= sysctl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // control outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= '0;
    end else begin
      ctl_ff.upstream_read_burst_en   <= ctl_reg_ff[sysctl_pkg::UP_BURST_BIT];    // R1
      ctl_ff.downstream_read_burst_en <= ctl_reg_ff[sysctl_pkg::DOWN_BURST_BIT];  // R17
      ctl_ff.auto_switch_gate         <= ctl_reg_ff[sysctl_pkg::AUTO_GATE_BIT];   // R8
      // only gate when every idle condition holds, so a waking card is never starved
      ctl_ff.card_sm_clk_en <= ~(ctl_reg_ff[sysctl_pkg::IDLE_GATE_BIT] & stat.card_is_32bit &
                                 stat.card_idle & stat.card_clk_stopped);        // R9
      ctl_ff.id_write_lock            <= ctl_reg_ff[sysctl_pkg::ID_LOCK_BIT];     // R10
      ctl_ff.syserr_req     <= ctl_reg_ff[sysctl_pkg::PARITY_BIT] & stat.card_parity_err;  // R11
      ctl_ff.central_dma_en <= ctl_reg_ff[sysctl_pkg::CDMA_BIT] &
                               aux_reg_ff[sysctl_pkg::PINS_CDMA_BIT];             // R12
      // supply select only matters in legacy mode; outside it report 3.3 V
      ctl_ff.legacy_supply_5v <= ctl_reg_ff[sysctl_pkg::SUPPLY_BIT] &
                                 aux_reg_ff[sysctl_pkg::LEGACY_MODE_BIT];         // R13
      ctl_ff.hold_clocks_running      <= ctl_reg_ff[sysctl_pkg::HOLD_CLOCKS_RUNNING_BIT];     // R14
      // shared wake pin: ring wins while the mux bit is clear, pme alone when it is set
      if (!ctl_reg_ff[sysctl_pkg::MUX_BIT]) begin
        ctl_ff.wake_pin_out <= ring_sync ? 1'b1 : pme_sync;  // R15
      end else begin
        ctl_ff.wake_pin_out <= pme_sync;  // R15
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign ctl           = ctl_ff;
endmodule
`default_nettype wire

// *** bench/sysctl_regs_assertions.sv ***
/*
  checker for sysctl_regs: bus answer timing, fixed read bits, output gating.
  assumes: one clock aclk, synchronous active-low aresetn, byte addresses.
*/
`default_nettype none
module sysctl_regs_assertions (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [7:0]               s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire sysctl_pkg::sysctl_stat_s stat,
  input wire sysctl_pkg::sysctl_ctl_s  ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_addr_ff; // address of the read in flight
  logic       live_ff;    // ctl is meaningful only from here on
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // remember the read address, the answer carries none
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_ff <= 8'h00;
      live_ff    <= 1'b0;
    end else begin
      live_ff <= 1'b1;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr_ff <= s_axi_araddr;
      end
    end
  end
  property p_b_after_both; $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready); endproperty
  a_b_after_both: assert property (p_b_after_both) else $error("write answer without both halves");
  property p_b_held; $fell(s_axi_bvalid) |-> $past(s_axi_bready); endproperty
  a_b_held: assert property (p_b_held) else $error("write answer dropped early");
  property p_r_latency; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_latency: assert property (p_r_latency) else $error("read answer late");
  property p_r_held; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_held: assert property (p_r_held) else $error("read answer not held");
  property p_rsvd_one; s_axi_rvalid && rd_addr_ff == sysctl_pkg::SYSCTL_OFFSET |-> s_axi_rdata[12]; endproperty
  a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bit read zero");
  property p_slverr_zero; s_axi_rvalid && s_axi_rresp == sysctl_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("refused read carries data");
  property p_reset_dflt;
    !$past(aresetn) |=> ctl.downstream_read_burst_en && ctl.id_write_lock && !ctl.upstream_read_burst_en;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("controls wrong after reset");
  property p_syserr; ctl.syserr_req |-> $past(stat.card_parity_err); endproperty
  a_syserr: assert property (p_syserr) else $error("system error without parity error");
  property p_clk_gate;
    live_ff && !ctl.card_sm_clk_en |-> $past(stat.card_is_32bit && stat.card_idle && stat.card_clk_stopped);
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("card clock stopped while busy");
  property p_wake_idle; !(stat.ring_req || stat.pme_req) [*8] |=> !ctl.wake_pin_out; endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("wake pin high with no source");
endmodule
bind sysctl_regs sysctl_regs_assertions i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .stat(stat), .ctl(ctl)
);
`default_nettype wire

// *** bench/tb.sv ***
/*
  self-checking bench for sysctl_regs: register access, status bits, steered outputs.
  assumes: package delay counts, aux register at 0x04 with legacy mode and dma pin bits.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;                // clock and reset
  logic [7:0]  awaddr, araddr;               // bus addresses
  logic [31:0] wdata, rdata, rd;             // write, read, last read word
  logic [3:0]  wstrb;                        // byte lanes
  logic [1:0]  bresp, rresp, rsp;            // responses, last taken
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  sysctl_pkg::sysctl_stat_s stat;            // card side stimulus
  sysctl_pkg::sysctl_ctl_s  ctl;             // steered controls
  int          err_total = 0;                // mismatches
  int          comparisons = 0;              // checks made
  sysctl_regs i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stat(stat), .ctl(ctl)
  );
  // verdict, the only exit
  task automatic end_sim;
    $display("mismatches %0d, checks %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 100) begin
      chk_w(n, 32'h0);
      end_sim();
    end
  endtask
  // both write halves offered together, bready up until the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    rsp = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  // rready raised only once rvalid is seen, so the hold gets exercised
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 100);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  task automatic t_reset;
    axi_rd(8'h00);
    chk_w(rd, 32'h0000_9020);
    chk_b(ctl.upstream_read_burst_en, 1'b0);
    chk_b(ctl.auto_switch_gate, 1'b0);
    chk_b(ctl.hold_clocks_running, 1'b0);
    chk_b(ctl.card_sm_clk_en, 1'b1);
  endtask
  // status bits ignore writes, lanes honoured
  task automatic t_fields;
    axi_wr(8'h00, 32'hffff_ffff, 4'hf);
    chk_w({30'h0, rsp}, 32'h0);
    axi_rd(8'h00);
    chk_w(rd, 32'h0000_d0ff);
    chk_b(ctl.upstream_read_burst_en, 1'b1);
    chk_b(ctl.auto_switch_gate, 1'b1);
    chk_b(ctl.hold_clocks_running, 1'b1);
    axi_wr(8'h00, 32'h0, 4'hf);
    axi_rd(8'h00);
    chk_w(rd, 32'h0000_1000);
    chk_b(ctl.downstream_read_burst_en, 1'b0);
    chk_b(ctl.id_write_lock, 1'b0);
    axi_wr(8'h00, 32'hffff_ffff, 4'h1);
    axi_rd(8'h00);
    chk_w(rd, 32'h0000_10ff);
  endtask
  task automatic t_status;
    @(posedge aclk) stat.card_access <= 1'b1;
    @(posedge aclk) stat.card_access <= 1'b0;
    axi_rd(8'h00);
    chk_b(rd[13], 1'b1);
    axi_rd(8'h00);
    chk_b(rd[13], 1'b0);
    // access in the very cycle of the clearing read: the set must win
    fork
      axi_rd(8'h00);
      begin
        @(posedge aclk) stat.card_access <= 1'b1;
        @(posedge aclk) stat.card_access <= 1'b0;
      end
    join
    axi_rd(8'h00);
    chk_b(rd[13], 1'b1);
    stat.probe_busy <= 1'b1;
    axi_rd(8'h00);
    chk_b(rd[8], 1'b1);
    stat.probe_busy <= 1'b0;
    axi_rd(8'h00);
    chk_b(rd[8], 1'b0);
  endtask
  // stream then settling delay; read just before and after expiry
  task automatic t_power(input bit up);
    int d;
    d = up ? sysctl_pkg::UP_DELAY_CYC : sysctl_pkg::DOWN_DELAY_CYC;
    @(posedge aclk) {stat.stream_start_up, stat.stream_start_dn} <= {up, !up};
    @(posedge aclk) {stat.stream_start_up, stat.stream_start_dn} <= 2'h0;
    axi_rd(8'h00);
    chk_b(rd[11], 1'b1);
    @(posedge aclk) stat.stream_done <= 1'b1;
    @(posedge aclk) stat.stream_done <= 1'b0;
    axi_rd(8'h00);
    chk_w({29'h0, rd[11:9]}, {29'h0, 1'b1, up, !up});
    repeat (d - 40) @(posedge aclk);
    axi_rd(8'h00);
    chk_w({29'h0, rd[11:9]}, {29'h0, 1'b1, up, !up});
    repeat (80) @(posedge aclk);
    axi_rd(8'h00);
    chk_w({29'h0, rd[11:9]}, 32'h0);
  endtask
  task automatic t_outputs;
    axi_wr(8'h00, 32'h0000_0050, 4'hf);
    stat.card_is_32bit <= 1'b1;
    stat.card_idle <= 1'b1;
    stat.card_clk_stopped <= 1'b1;
    stat.card_parity_err <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_b(ctl.card_sm_clk_en, 1'b0);
    chk_b(ctl.syserr_req, 1'b1);
    axi_wr(8'h00, 32'h0, 4'hf);
    repeat (4) @(posedge aclk);
    chk_b(ctl.card_sm_clk_en, 1'b1);
    chk_b(ctl.syserr_req, 1'b0);
    for (int i = 0; i < 8; i++) begin
      axi_wr(8'h04, {30'h0, i[1:0]}, 4'hf);
      axi_wr(8'h00, {28'h0, 1'b1, i[2], 2'h0}, 4'hf);
      repeat (4) @(posedge aclk);
      chk_b(ctl.central_dma_en, i[1]);
      chk_b(ctl.legacy_supply_5v, i[0] & i[2]);
    end
    axi_wr(8'h00, 32'h0, 4'hf);
    repeat (4) @(posedge aclk);
    chk_b(ctl.central_dma_en, 1'b0);
  endtask
  // ring and pme sources through the pin synchroniser, both mux settings
  task automatic t_wake;
    for (int m = 0; m < 2; m++) begin
      axi_wr(8'h00, {31'h0, m[0]}, 4'hf);
      for (int k = 1; k < 4; k++) begin
        stat.ring_req <= k[0];
        stat.pme_req <= k[1];
        repeat (10) @(posedge aclk);
        chk_b(ctl.wake_pin_out, m[0] ? k[1] : k[0] | k[1]);
      end
      stat.ring_req <= 1'b0;
      stat.pme_req <= 1'b0;
      repeat (10) @(posedge aclk);
      chk_b(ctl.wake_pin_out, 1'b0);
    end
  endtask
  task automatic t_unmapped;
    axi_rd(8'h08);
    chk_w({30'h0, rsp}, {30'h0, sysctl_pkg::RESP_SLVERR});
    chk_w(rd, 32'h0);
    axi_wr(8'h08, 32'hffff_ffff, 4'hf);
    chk_w({30'h0, rsp}, {30'h0, sysctl_pkg::RESP_SLVERR});
  endtask
  // free running clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    stat = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_status();
    t_power(1'b1);
    t_power(1'b0);
    t_outputs();
    t_wake();
    t_unmapped();
    end_sim();
  end
endmodule
`default_nettype wire
